// ===== verilog/hsp_consts.svh
// Named constants shared by both ends of the host serial port
// Behaviour
// - 4-wire uses select, clock, separate data lines
// - 3-wire shares one bidirectional data line
// - Data-in pin turns around in 3-wire mode
// - Mode bit 7 set selects 3-wire
// - Power-up default is 4-wire operation
// - Receiver samples data on rising clock edge
// - Transmitter changes data on falling clock edge
// - Host keeps serial clock at most 10 MHz
// - Every byte shifts most significant bit first
// - Single and burst transfers, read and write
// - Host writes configuration registers singly only
// - Address byte: direction, increment, 6-bit address
// - Direction 1 means read, 0 write
// - Host clears increment flag for single transfers
// - Incrementing burst read walks successive addresses
// - Incrementing burst write stores at successive addresses
// - Non-incrementing burst stays on one address
`ifndef HSP_CONSTS_SVH
`define HSP_CONSTS_SVH

// Address byte layout
`define HSP_RW_BIT         7
`define HSP_INC_BIT        6
`define HSP_ADDR_MSB       5
// Register file of the device
`define HSP_REG_COUNT      64
`define HSP_REG_RESET      8'h00
`define HSP_FCR_ADDR       6'h02
`define HSP_MODE_BIT       7
`define HSP_LAST_BIT       3'h7
`define HSP_ADDR_STEP      6'h01
// Idle level of select, clock and data pins
`define HSP_PIN_IDLE       3'h7
`define HSP_LINE_PULL      1'b1
// Timing
`define HSP_CLK_PERIOD_NS  50
`define HSP_SCLK_PERIOD_NS 400
`define HSP_SCLK_MIN_NS    100
`define HSP_HALF_LAST      3'((`HSP_SCLK_PERIOD_NS / `HSP_CLK_PERIOD_NS) / 2 - 1)
// Host register offsets on the Avalon-MM slave
`define HSP_OFS_CMD        4'h0
`define HSP_OFS_DATA       4'h4
`define HSP_OFS_STAT       4'h8
// Host command and status fields
`define HSP_CMD_OPEN       0
`define HSP_CMD_CLOSE      1
`define HSP_CMD_3W         2
`define HSP_CMD_ABYTE_MSB  15
`define HSP_CMD_ABYTE_LSB  8
`define HSP_ST_BUSY        0
`define HSP_ST_OPEN        1
`define HSP_ST_3W          2
`define HSP_WORD_ZERO      32'h00000000

`endif

// ===== verilog/hsp_pkg.sv
// Types shared by both ends of the host serial port
`default_nettype none
package hsp_pkg;
  typedef logic [7:0] hsp_byte_type;  // One data or address byte
  typedef logic [5:0] hsp_addr_type;  // Register address
  typedef enum logic [3:0] {
    D_IDLE = 4'b0001,
    D_ADDR = 4'b0010,
    D_WR   = 4'b0100,
    D_RD   = 4'b1000
  } hsp_dev_state_type;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_FALL = 3'b010,
    H_RISE = 3'b100
  } hsp_host_state_type;
endpackage : hsp_pkg
`default_nettype wire

// ===== verilog/hsp_link_if.sv
// Serial link pins between host and device, with line resolution
`timescale 1ns/1ps
`default_nettype none
`include "hsp_consts.svh"
interface hsp_link_if;
  logic chip_sel_n;           // Frame select, low active
  logic serial_clock_pin;     // Clock made by the host
  logic host_data_o;          // Host drive of data-in pin
  logic host_data_oe;         // Host enable on data-in pin
  logic dev_data_o;           // Device data bit
  logic dev_data_in_oe;       // Device enable on data-in pin, 3-wire
  logic dev_data_out_oe;      // Device enable on data-out pin, 4-wire
  logic serial_data_in_line;  // Resolved data-in pin
  logic serial_data_out_line; // Resolved data-out pin

  // Undriven lines float to the pull-up level
  assign serial_data_in_line = dev_data_in_oe ? dev_data_o :
                               (host_data_oe ? host_data_o : `HSP_LINE_PULL);
  assign serial_data_out_line = dev_data_out_oe ? dev_data_o : `HSP_LINE_PULL;

  modport device (
    input  chip_sel_n, serial_clock_pin, serial_data_in_line,
    output dev_data_o, dev_data_in_oe, dev_data_out_oe
  );
  modport host (
    output chip_sel_n, serial_clock_pin, host_data_o, host_data_oe,
    input  serial_data_in_line, serial_data_out_line
  );
endinterface : hsp_link_if
`default_nettype wire

// ===== verilog/hsp_device.sv
// Device end: serial slave port with its byte register file
`timescale 1ns/1ps
`default_nettype none
`include "hsp_consts.svh"
module hsp_device (
  input  wire logic                 CLK,        // System clock
  input  wire logic                 RESET_N,    // Async reset, low active
  hsp_link_if.device                LINK,       // Serial pins
  output logic                      THREE_WIRE, // Current link mode
  output logic                      WR_STROBE,  // Pulse per stored byte
  output var hsp_pkg::hsp_addr_type WR_ADDR,    // Address of stored byte
  output var hsp_pkg::hsp_byte_type WR_DATA     // Value of stored byte
);
  import hsp_pkg::*;

  // The host pins come from outside this clock, so each passes two flip-flops
  // before any decode. Select, clock and data share one pipeline, so their
  // order is kept and a data bit is read with the clock edge that framed it.
  // Cost: a read answer lags the host's falling edge by three cycles, which
  // leaves one cycle of margin at a half period of four cycles.
  // A faster link clock would need a shorter pipeline or a delayed sample.
  // Pin synchronisers: select, clock, data in
  logic [2:0]        sync_a;     // First stage, read only by sync_b
  logic [2:0]        sync_b;     // Second stage
  logic              sclk_prev;  // Previous synced clock
  // Frame decoding
  hsp_dev_state_type state;      // Frame phase
  hsp_dev_state_type next_state; // Phase for next cycle
  logic [2:0]        bit_cnt;    // Bit within byte
  hsp_byte_type      shift_in;   // Received bits
  hsp_addr_type      addr;       // Current register address
  logic              inc;        // Auto-increment flag of frame
  hsp_byte_type      tx_sh;      // Bits still to send
  logic              dout;       // Data bit on the pin
  logic              oe_in_pin;  // Drive on shared pin
  logic              oe_out_pin; // Drive on output pin
  hsp_byte_type      regs [`HSP_REG_COUNT]; // Register file

  // Named decode of the synchronised pins
  wire          cs_low    = ~sync_b[2];
  wire          sclk_s    = sync_b[1];
  wire          din_s     = sync_b[0];
  // Link clock edges count only while select is low
  wire          rise      = cs_low & sclk_s & ~sclk_prev;
  wire          fall      = cs_low & ~sclk_s & sclk_prev;
  wire          byte_done = rise & (bit_cnt == `HSP_LAST_BIT);
  wire [7:0]    rx_byte   = {shift_in[6:0], din_s};
  // Frame phase flags
  wire          in_addr   = (state == D_ADDR);
  wire          in_wr     = (state == D_WR);
  wire          in_rd     = (state == D_RD);
  wire          is_read   = rx_byte[`HSP_RW_BIT];
  // Increment or hold the address between data bytes
  wire [5:0]    next_addr = inc ? addr + `HSP_ADDR_STEP : addr;
  // Store and load strobes, both at a byte end
  wire          wr_hit    = in_wr & byte_done;
  wire          rd_load   = byte_done & ((in_addr & is_read) | in_rd);
  wire [5:0]    load_addr = in_addr ? rx_byte[`HSP_ADDR_MSB:0] : next_addr;
  wire          mode3     = regs[`HSP_FCR_ADDR][`HSP_MODE_BIT];

  assign THREE_WIRE = mode3;

  // Two flip-flops before any logic reads a pin
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_a    <= `HSP_PIN_IDLE;
      sync_b    <= `HSP_PIN_IDLE;
      sclk_prev <= 1'b1;
    end else begin
      sync_a    <= {LINK.chip_sel_n, LINK.serial_clock_pin, LINK.serial_data_in_line};
      sync_b    <= sync_a;
      sclk_prev <= sync_b[1];
    end
  end

  // Frame phase register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= D_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase walk: address byte first, then data bytes
  // A read address byte leads to the answer phase, a write one to storing
  // Only a released select leaves a data phase, so bursts have no length limit
  always_comb begin
    next_state = state;
    unique case (state)
      D_IDLE: begin
        if (cs_low) begin
          next_state = D_ADDR;
        end
      end
      D_ADDR: begin
        if (!cs_low) begin
          next_state = D_IDLE;
        end else if (byte_done) begin
          next_state = is_read ? D_RD : D_WR;
        end
      end
      D_WR, D_RD: begin
        // Bursts continue until select is released
        if (!cs_low) begin
          next_state = D_IDLE;
        end
      end
    endcase
  end

  // Bit counter and input shifter; a released select clears the count
  // A partial byte at select release is dropped with the count
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bit_cnt  <= 3'h0;
      shift_in <= `HSP_REG_RESET;
    end else if (!cs_low) begin
      bit_cnt  <= 3'h0;
    end else if (rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= rx_byte;
    end
  end

  // Address and increment flag from the first byte, then stepped per byte
  // Without the increment flag every byte of a burst reuses one address
  // With it the address wraps from the top register back to zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      addr <= 6'h00;
      inc  <= 1'b0;
    end else if (in_addr & byte_done) begin
      addr <= rx_byte[`HSP_ADDR_MSB:0];
      inc  <= rx_byte[`HSP_INC_BIT];
    end else if (byte_done & (in_wr | in_rd)) begin
      addr <= next_addr;
    end
  end

  // Register file; every entry resets to zero, so the link starts in 4-wire
  // Each entry has its own enable, so one stored byte touches one entry only
  // Storing bit 7 of the control register switches the link mode at once
  for (genvar i = 0; i < `HSP_REG_COUNT; i++) begin : g_reg
    wire hit = wr_hit & (addr == 6'(i));
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        regs[i] <= `HSP_REG_RESET;
      end else if (hit) begin
        regs[i] <= rx_byte;
      end
    end
  end

  // Write report to the user side, one pulse per byte
  // Address and data are loaded every cycle; only the strobe qualifies them
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WR_STROBE <= 1'b0;
      WR_ADDR   <= 6'h00;
      WR_DATA   <= `HSP_REG_RESET;
    end else begin
      WR_STROBE <= wr_hit;
      WR_ADDR   <= addr;
      WR_DATA   <= rx_byte;
    end
  end

  // Output shifter: loaded at each byte end of a read frame, shifted on each falling edge of the read data phase
  // Loading at the rising edge gives a whole half period before the next fall
  // Each bit then stands from one host fall to the next, across the host sample
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_sh <= `HSP_REG_RESET;
      dout  <= `HSP_LINE_PULL;
    end else if (rd_load) begin
      tx_sh <= regs[load_addr];
    end else if (in_rd & fall) begin
      dout  <= tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // Pin direction: drive only in the read data phase, pin chosen by mode
  // The mode is sampled per bit, so a mode change mid-frame takes effect
  // from the next falling edge; hosts should change it in a write frame
  // Drive stops three cycles after select rises, inside the host's select gap,
  // so the host never finds the shared pin still driven at its next frame
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      oe_in_pin  <= 1'b0;
      oe_out_pin <= 1'b0;
    end else if (!cs_low | ~in_rd) begin
      oe_in_pin  <= 1'b0;
      oe_out_pin <= 1'b0;
    end else if (fall) begin
      oe_in_pin  <= mode3;
      oe_out_pin <= ~mode3;
    end
  end

  // Pin drives leave straight from flip-flops
  assign LINK.dev_data_o      = dout;
  assign LINK.dev_data_in_oe  = oe_in_pin;
  assign LINK.dev_data_out_oe = oe_out_pin;

endmodule : hsp_device
`default_nettype wire

// ===== verilog/hsp_host.sv
// Host end: serial master driven by software over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`include "hsp_consts.svh"
module hsp_host (
  input  wire logic        CLK,             // System clock
  input  wire logic        RESET_N,         // Async reset, low active
  input  wire logic [3:0]  AVS_ADDRESS,     // Byte address
  input  wire logic        AVS_READ,        // Read request
  input  wire logic        AVS_WRITE,       // Write request
  input  wire logic [31:0] AVS_WRITEDATA,   // Write data
  output logic      [31:0] AVS_READDATA,    // Read data
  output logic             AVS_WAITREQUEST, // Stall, high until answered
  hsp_link_if.host         LINK             // Serial pins
);
  import hsp_pkg::*;

  hsp_host_state_type state;      // Shifter phase
  hsp_host_state_type next_state; // Phase for next cycle
  logic [2:0]         div;        // Half-period counter
  logic [2:0]         bit_cnt;    // Bit within byte
  hsp_byte_type       sh;         // Bits to send
  hsp_byte_type       rx;         // Bits received
  logic               three_wire; // Link mode, must match the device
  logic               rd_frame;   // Frame is a read
  logic               data_phase; // Address byte already sent
  logic               cs_n;       // Select pin
  logic               sclk;       // Clock pin, idles high
  logic               dat_o;      // Data-in pin value
  logic               dat_oe;     // Data-in pin enable

  // Bus decode
  wire       busy     = (state != H_IDLE);
  wire       sel_cmd  = (AVS_ADDRESS == `HSP_OFS_CMD);
  wire       sel_data = (AVS_ADDRESS == `HSP_OFS_DATA);
  wire       sel_stat = (AVS_ADDRESS == `HSP_OFS_STAT);
  // A shift in progress stalls commands and data access
  wire       stall    = busy & ((AVS_WRITE & (sel_cmd | sel_data)) | (AVS_READ & sel_data));
  wire       take     = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & ~stall;
  wire       wr_cmd   = take & AVS_WRITE & sel_cmd;
  wire       open_req = wr_cmd & AVS_WRITEDATA[`HSP_CMD_OPEN];
  wire       close_rq = wr_cmd & ~AVS_WRITEDATA[`HSP_CMD_OPEN] & AVS_WRITEDATA[`HSP_CMD_CLOSE];
  wire       wr_data  = take & AVS_WRITE & sel_data & ~cs_n;
  wire       load     = open_req | wr_data;
  wire [7:0] abyte    = AVS_WRITEDATA[`HSP_CMD_ABYTE_MSB:`HSP_CMD_ABYTE_LSB];
  wire [7:0] ld_byte  = open_req ? abyte : AVS_WRITEDATA[7:0];
  wire [31:0] rd_mux  = sel_data ? {24'h000000, rx} :
                        (sel_cmd | sel_stat) ?
                        {29'h00000000, three_wire, ~cs_n, busy} : `HSP_WORD_ZERO;
  // Shifter timing
  wire       tick     = (div == `HSP_HALF_LAST);
  wire       last_bit = (bit_cnt == `HSP_LAST_BIT);
  wire       line_in  = three_wire ? LINK.serial_data_in_line : LINK.serial_data_out_line;
  // Release the shared pin while the device answers a read
  wire       drive    = ~(three_wire & rd_frame & data_phase);

  // Bus answer: one cycle of low waitrequest per taken request
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= `HSP_WORD_ZERO;
    end else begin
      AVS_WAITREQUEST <= ~take;
      AVS_READDATA    <= take ? rd_mux : AVS_READDATA;
    end
  end

  // Mode setting, rewritten by every command write
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      three_wire <= 1'b0;
    end else if (wr_cmd) begin
      three_wire <= AVS_WRITEDATA[`HSP_CMD_3W];
    end
  end

  // Frame control: select falls with the address byte, rises on close
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_n       <= 1'b1;
      rd_frame   <= 1'b0;
      data_phase <= 1'b0;
    end else if (open_req) begin
      cs_n       <= 1'b0;
      rd_frame   <= abyte[`HSP_RW_BIT];
      data_phase <= 1'b0;
    end else if (close_rq) begin
      cs_n       <= 1'b1;
    end else if (state == H_RISE && tick && last_bit) begin
      data_phase <= 1'b1;
    end
  end

  // Shifter phase register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= H_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // One byte is eight fall and rise half periods
  always_comb begin
    next_state = state;
    unique case (state)
      H_IDLE: begin
        if (load) begin
          next_state = H_FALL;
        end
      end
      H_FALL: begin
        if (tick) begin
          next_state = H_RISE;
        end
      end
      H_RISE: begin
        if (tick) begin
          next_state = last_bit ? H_IDLE : H_FALL;
        end
      end
    endcase
  end

  // Clock divider and bit counter
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div     <= 3'h0;
      bit_cnt <= 3'h0;
    end else begin
      div     <= (!busy || tick) ? 3'h0 : div + 3'h1;
      bit_cnt <= (state == H_RISE && tick) ? bit_cnt + 3'h1 : bit_cnt;
    end
  end

  // Clock pin and sampling of the returned data
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sclk <= 1'b1;
      rx   <= `HSP_REG_RESET;
    end else if (state == H_FALL && tick) begin
      sclk <= 1'b0;
    end else if (state == H_RISE && tick) begin
      sclk <= 1'b1;
      rx   <= {rx[6:0], line_in};
    end
  end

  // Output shifter and data-in pin drive
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sh     <= `HSP_REG_RESET;
      dat_o  <= `HSP_LINE_PULL;
      dat_oe <= 1'b0;
    end else if (load) begin
      sh     <= ld_byte;
      dat_o  <= open_req ? ld_byte[7] : dat_o;
      dat_oe <= open_req ? 1'b1 : dat_oe;
    end else if (close_rq) begin
      dat_oe <= 1'b0;
    end else if (state == H_FALL && tick) begin
      dat_o  <= sh[7];
      sh     <= {sh[6:0], 1'b0};
      dat_oe <= drive;
    end
  end

  assign LINK.chip_sel_n       = cs_n;
  assign LINK.serial_clock_pin = sclk;
  assign LINK.host_data_o      = dat_o;
  assign LINK.host_data_oe     = dat_oe;

endmodule : hsp_host
`default_nettype wire

// ===== test/hsp_assertions.sv
// Concurrent checks on the serial link between host end and device end
`timescale 1ns/1ps
`default_nettype none
module hsp_assertions (
  input wire logic CLK,              // System clock
  input wire logic RESET_N,          // Async reset, low active
  input wire logic chip_sel_n,       // Frame select
  input wire logic serial_clock_pin, // Link clock from host
  input wire logic host_data_o,      // Host data bit
  input wire logic host_data_oe,     // Host enable on shared pin
  input wire logic dev_data_o,       // Device data bit
  input wire logic dev_data_in_oe,   // Device enable, shared pin
  input wire logic dev_data_out_oe   // Device enable, output pin
);
  // One domain only, so clock and reset are given once
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  wire dev_oe = dev_data_in_oe | dev_data_out_oe; // Device drives some pin

  // Device turns only one pin around, chosen by mode
  a_oe_one_pin: assert property (!(dev_data_in_oe && dev_data_out_oe))
    else $error("device drives both data pins");
  // Shared pin never driven by both ends
  a_no_fight: assert property (!(dev_data_in_oe && host_data_oe))
    else $error("both ends drive the shared pin");
  // Sync delay of select bounded well below eight cycles
  a_hiz_idle: assert property (chip_sel_n [*8] |-> !dev_oe)
    else $error("device drives outside a frame");
  a_sclk_idle: assert property (chip_sel_n |-> serial_clock_pin)
    else $error("link clock low outside a frame");
  // Half period of four cycles keeps the link under its ceiling
  a_sclk_low: assert property ($fell(serial_clock_pin) |-> !serial_clock_pin [*4] ##1 serial_clock_pin)
    else $error("link clock low phase wrong");
  a_sclk_high: assert property ($rose(serial_clock_pin) |-> serial_clock_pin [*4])
    else $error("link clock high phase too short");
  a_frame_lead: assert property ($fell(chip_sel_n) |-> serial_clock_pin [*4])
    else $error("clock falls too soon after select");
  a_frame_gap: assert property ($rose(chip_sel_n) |-> chip_sel_n [*3])
    else $error("select high gap too short");
  // Host moves its data only with the falling link clock
  a_host_fall: assert property (!chip_sel_n && host_data_oe && $past(host_data_oe) && $changed(host_data_o)
    |-> $fell(serial_clock_pin))
    else $error("host data moved off the falling clock");
  // Device moves its data in the low phase, after the fall
  a_dev_fall: assert property (dev_oe && $past(dev_oe) && $changed(dev_data_o)
    |-> !serial_clock_pin && !$past(serial_clock_pin, 2))
    else $error("device data moved off the low phase");
endmodule : hsp_assertions
`default_nettype wire

// ===== test/tb_top.sv
// Testbench joining host end and device end over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "hsp_consts.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic        clk, rst_n;                         // Clock and reset
  logic [3:0]  avs_address;                        // Bus request signals
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, avs_readdata;
  logic        avs_waitrequest, three_wire;
  logic        wr_strobe;                          // Device store report
  logic [5:0]  wr_addr;
  logic [7:0]  wr_data, mem [64];                  // Reference register file
  logic [15:0] lfsr;                               // Random source
  logic [13:0] exp_q [$], obs_q [$];               // Expected and seen stores
  logic        three_w, sclk_q;                    // Mode the bench asked for
  logic [7:0]  wire_sh, wire_ab;                   // First byte seen on the pin
  int          n_mismatch, checks_done, cyc, wire_n;

  hsp_link_if link ();
  hsp_host i_hsp_host (.CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .LINK(link));
  hsp_device i_hsp_device (.CLK(clk), .RESET_N(rst_n), .LINK(link), .THREE_WIRE(three_wire),
    .WR_STROBE(wr_strobe), .WR_ADDR(wr_addr), .WR_DATA(wr_data));
  hsp_assertions u_chk (.CLK(clk), .RESET_N(rst_n), .chip_sel_n(link.chip_sel_n),
    .serial_clock_pin(link.serial_clock_pin), .host_data_o(link.host_data_o),
    .host_data_oe(link.host_data_oe), .dev_data_o(link.dev_data_o),
    .dev_data_in_oe(link.dev_data_in_oe), .dev_data_out_oe(link.dev_data_out_oe));

  // Clock of 50 ns
  always #25 clk = ~clk;

  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      close_out();
    end
  end

  // Collect every stored byte the device reports
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) obs_q.push_back({wr_addr, wr_data});
  end

  // Shift in the pin at each rising link clock; first byte is the address
  always @(posedge clk) begin
    sclk_q <= link.serial_clock_pin;
    if (link.chip_sel_n) begin
      wire_n <= 0;
    end else if (link.serial_clock_pin && !sclk_q) begin
      wire_sh = {wire_sh[6:0], link.serial_data_in_line};
      wire_n <= wire_n + 1;
      if (wire_n == 7) wire_ab <= wire_sh;
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  // Address of the next byte of a burst; wraps after the top register
  function automatic logic [5:0] step_addr(input logic [5:0] p, input logic inc);
    step_addr = inc ? p + 6'h01 : p;
  endfunction : step_addr

  // Wait for the answer; the edge that sees waitrequest low ends the request
  task automatic wait_ack;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
  endtask : wait_ack

  // Extra edge after release so a following request never lands in the same step
  task automatic av_write(input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av_write

  task automatic av_read(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : av_read

  // One whole frame; fv below zero asks for random write data
  task automatic frame(input logic rd, input logic inc, input logic [5:0] a, input int n, input int fv);
    logic [7:0]  ab, d;
    logic [5:0]  p;
    logic [31:0] r;
    ab = {rd, inc, a};
    p  = a;
    av_write(`HSP_OFS_CMD, {16'h0000, ab, 5'h00, three_w, 2'b01});
    av_read(`HSP_OFS_STAT, r);
    `CHK("status open", ({29'h00000000, three_w, 2'b11}), r)
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      d = (fv < 0) ? lfsr[7:0] : fv[7:0];
      av_write(`HSP_OFS_DATA, {24'h000000, d});
      if (rd) begin
        av_read(`HSP_OFS_DATA, r);
        `CHK("read byte", mem[p], r[7:0])
      end else begin
        mem[p] = d;
        exp_q.push_back({p, d});
      end
      p = step_addr(p, inc);
    end
    av_write(`HSP_OFS_CMD, {29'h00000000, three_w, 2'b10});
    av_read(`HSP_OFS_CMD, r);
    `CHK("status closed", ({29'h00000000, three_w, 2'b00}), r)
    repeat (16) if (obs_q.size() < exp_q.size()) @(posedge clk);
    `CHK("address byte", ab, wire_ab)
    `CHK("store count", exp_q.size(), obs_q.size())
    foreach (exp_q[j]) `CHK("stored byte", exp_q[j], obs_q[j])
    exp_q.delete();
    obs_q.delete();
  endtask : frame

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // Main sequence: both modes, wrap corner, random bursts, mode switch
  initial begin
    clk = 1'b0; rst_n = 1'b0; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h00000000; lfsr = 16'h002A; three_w = 1'b0; sclk_q = 1'b1;
    n_mismatch = 0; checks_done = 0; cyc = 0; wire_n = 0;
    foreach (mem[k]) mem[k] = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("mode after reset", 1'b0, three_wire)
    for (int m = 0; m < 2; m++) begin
      frame(1'b0, 1'b1, 6'h3F, 2, -1);
      frame(1'b1, 1'b1, 6'h3F, 2, -1);
      // Bursts start high enough to never walk onto the control register
      for (int k = 0; k < 6; k++) begin
        lfsr = lfsr_next(lfsr);
        // Single-byte frames keep the increment flag clear
        frame(1'b0, lfsr[10] & (lfsr[9:8] != 2'b00), 6'(8 + lfsr[5:0] % 50), 1 + lfsr[9:8], -1);
        frame(1'b1, lfsr[10] & (lfsr[9:8] != 2'b00), 6'(8 + lfsr[5:0] % 50), 1 + lfsr[9:8], -1);
      end
      frame(1'b0, 1'b0, `HSP_FCR_ADDR, 1, (m == 0) ? 128 : 0);
      three_w = (m == 0);
      `CHK("link mode", three_w, three_wire)
      frame(1'b1, 1'b0, `HSP_FCR_ADDR, 1, -1);
      $display("test in mode %0d done", m);
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
